/* shared/gate_fault_pkg.sv */
// Package with constants and carrier types for the half-bridge gate fault logic.
package gate_fault_pkg;

  // Clock and timing figures.
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned OC_OFF_MAX_NS   = 150;
  localparam int unsigned OC_OFF_CYCLES   =
    (OC_OFF_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : (OC_OFF_MAX_NS / CLK_PERIOD_NS);
  localparam int unsigned PUMP_CLK_HZ     = 600_000;
  localparam int unsigned PUMP_HALF_DIV   = CLK_HZ / (2 * PUMP_CLK_HZ);
  localparam int unsigned PUMP_CNT_W      = 8;
  localparam logic [PUMP_CNT_W-1:0] PUMP_HALF_LAST =
    PUMP_CNT_W'(PUMP_HALF_DIV - 1);
  localparam logic [PUMP_CNT_W-1:0] PUMP_CNT_RST = 8'h00;

  // Analogue comparator results, already digitised, for one die.
  typedef struct packed {
    logic current_high;   // Current sense above its threshold.
    logic pos_supply_low; // Positive supply below its trip point.
    logic neg_supply_bad; // Negative supply above its fault level.
    logic pump_over;      // Supply difference above the pump limit.
  } die_sense_s;

  // Status of one die's protection.
  typedef struct packed {
    logic oc_latched;
    logic uv_lock;
    logic gate_on;
  } die_status_s;

  localparam die_status_s DIE_STATUS_RST = '{1'b0, 1'b1, 1'b0};

endpackage : gate_fault_pkg

/* src/half_bridge_gate_fault_logic.sv */
// Protection and gate control logic of a two-die half-bridge driver.
//
// Function
// - Low-side gate on while low-side command high, off when low.
// - High-side gate follows high-side command forwarded from low-side die.
// - Upward channel carries high-side command, downward channel carries fault.
// - High-side fault arriving downward pulls the shared fault output low.
// - Returned high-side fault is status only; high die shuts itself.
// - Overcurrent or supply undervoltage forces that die's gate off.
// - Overcurrent sensing counts only while that die's gate is on.
// - Overcurrent latch clears only on next command rising edge.
// - One open-drain fault output, low for fault on either die.
// - Gate turns off within 150 ns of sensed overcurrent.
// - Lockout keeps both gates from being on together.
// - At power-up both gates held off until supply reaches trip point.
// - Positive supply below trip point locks gate off.
// - Negative supply above fault level locks gate off.
// - Charge-pump clock near 600 kHz, stopped above 20 V difference.
// - Fault stays low until next input cycle or supply recovery.
// - Low-side command high turns gate on and resets fault logic.
// - A side turns on only after the other side was commanded off.
`timescale 1ns/1ps

module half_bridge_gate_fault_logic
  import gate_fault_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        low_side_command_in,
  input  wire logic        high_side_command_in,
  input  wire die_sense_s  low_sense,
  input  wire die_sense_s  high_sense,
  output logic             low_gate_out,
  output logic             high_gate_out,
  output logic             up_channel_out,
  output logic             down_channel_out,
  output logic             fault_n_out,
  output logic             fault_n_oe,
  output logic             low_pump_clk,
  output logic             high_pump_clk,
  output die_status_s      low_status,
  output die_status_s      high_status
);

  // Two-flop synchronisers for both commands and all sense inputs.
  logic [1:0] cmd_meta;
  logic [1:0] cmd_sync;
  logic [1:0] cmd_prev;
  die_sense_s low_meta;
  die_sense_s low_s;
  die_sense_s high_meta;
  die_sense_s high_s;
  logic [1:0] next_cmd_meta;
  logic [1:0] next_cmd_sync;
  logic [1:0] next_cmd_prev;

  always_comb
  begin
    next_cmd_meta = {high_side_command_in, low_side_command_in};
    next_cmd_sync = cmd_meta;
    next_cmd_prev = cmd_sync;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cmd_meta  <= 2'h0;
      cmd_sync  <= 2'h0;
      cmd_prev  <= 2'h0;
      low_meta  <= '0;
      low_s     <= '0;
      high_meta <= '0;
      high_s    <= '0;
    end
    else
    begin
      cmd_meta  <= next_cmd_meta;
      cmd_sync  <= next_cmd_sync;
      cmd_prev  <= next_cmd_prev;
      low_meta  <= low_sense;
      low_s     <= low_meta;
      high_meta <= high_sense;
      high_s    <= high_meta;
    end
  end

  logic low_cmd;
  logic high_cmd;
  logic low_rise;
  logic high_rise;

  assign low_cmd   = cmd_sync[0];
  assign high_cmd  = cmd_sync[1];
  assign low_rise  = cmd_sync[0] & ~cmd_prev[0];
  assign high_rise = cmd_sync[1] & ~cmd_prev[1];

  // Upward channel: the high-side command as a registered level.
  logic up_link;
  logic next_up_link;
  logic high_prev_link;
  // Downward channel: the high die's fault state returned as a level.
  logic down_link;
  logic next_down_link;

  die_status_s low_st;
  die_status_s high_st;
  die_status_s next_low_st;
  die_status_s next_high_st;

  // Side that may drive: a side is armed only after the other was
  // commanded off, so overlapping commands keep the late one off.
  logic low_armed;
  logic high_armed;
  logic next_low_armed;
  logic next_high_armed;

  logic low_oc_now;
  logic high_oc_now;
  logic low_uv;
  logic high_uv;

  assign low_uv  = low_s.pos_supply_low | low_s.neg_supply_bad;
  assign high_uv = high_s.pos_supply_low | high_s.neg_supply_bad;
  // Sense only counts while the gate is on; off-state readings are noise.
  assign low_oc_now  = low_s.current_high & low_st.gate_on;
  assign high_oc_now = high_s.current_high & high_st.gate_on;

  always_comb
  begin
    next_up_link    = high_cmd;
    next_low_armed  = low_armed;
    next_high_armed = high_armed;
    if (!low_cmd)
    begin
      next_high_armed = 1'b1;
    end
    if (!up_link)
    begin
      next_low_armed = 1'b1;
    end
    if (low_cmd && up_link && !low_st.gate_on)
    begin
      next_low_armed = 1'b0;
    end
    if (up_link && low_cmd && !high_st.gate_on)
    begin
      next_high_armed = 1'b0;
    end

    // Low die: the set of the latch wins over a clearing edge.
    next_low_st          = low_st;
    next_low_st.uv_lock  = low_uv;
    if (low_rise)
    begin
      next_low_st.oc_latched = 1'b0;
    end
    if (low_oc_now)
    begin
      next_low_st.oc_latched = 1'b1;
    end
    next_low_st.gate_on = low_cmd && next_low_armed && !low_uv
                          && !low_oc_now && !next_low_st.oc_latched
                          && !high_st.gate_on;

    // High die takes its command from the upward channel; its gate also checks low_cmd and the low gate.
    next_high_st         = high_st;
    next_high_st.uv_lock = high_uv;
    if (up_link && !high_st.gate_on && !high_prev_link)
    begin
      next_high_st.oc_latched = 1'b0;
    end
    if (high_oc_now)
    begin
      next_high_st.oc_latched = 1'b1;
    end
    // High-side shutdown is decided here only, never from the status path.
    next_high_st.gate_on = up_link && next_high_armed && !high_uv
                           && !high_oc_now && !next_high_st.oc_latched
                           && !low_st.gate_on && !low_cmd;

    next_down_link = next_high_st.oc_latched | high_uv;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      up_link        <= 1'b0;
      down_link      <= 1'b0;
      low_st         <= DIE_STATUS_RST;
      high_st        <= DIE_STATUS_RST;
      low_armed      <= 1'b0;
      high_armed     <= 1'b0;
      high_prev_link <= 1'b0;
    end
    else
    begin
      up_link        <= next_up_link;
      down_link      <= next_down_link;
      low_st         <= next_low_st;
      high_st        <= next_high_st;
      low_armed      <= next_low_armed;
      high_armed     <= next_high_armed;
      high_prev_link <= up_link;
    end
  end

  // Shared fault pin: open drain, driven low only.
  logic fault_any;
  logic next_fault_any;

  always_comb
  begin
    next_fault_any = next_low_st.oc_latched | low_uv | down_link;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      fault_any <= 1'b1;
    end
    else
    begin
      fault_any <= next_fault_any;
    end
  end

  assign fault_n_out = 1'b0;
  assign fault_n_oe  = fault_any;

  // Charge pumps: a divider toggles each pump clock, held while over limit.
  logic [PUMP_CNT_W-1:0] pump_cnt;
  logic [PUMP_CNT_W-1:0] next_pump_cnt;
  logic                  low_pump;
  logic                  high_pump;
  logic                  next_low_pump;
  logic                  next_high_pump;
  logic                  pump_tick;

  assign pump_tick = (pump_cnt == PUMP_HALF_LAST);

  always_comb
  begin
    next_pump_cnt  = pump_tick ? PUMP_CNT_RST : pump_cnt + 8'h01;
    next_low_pump  = low_pump;
    next_high_pump = high_pump;
    if (pump_tick && !low_s.pump_over)
    begin
      next_low_pump = ~low_pump;
    end
    if (pump_tick && !high_s.pump_over)
    begin
      next_high_pump = ~high_pump;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pump_cnt  <= PUMP_CNT_RST;
      low_pump  <= 1'b0;
      high_pump <= 1'b0;
    end
    else
    begin
      pump_cnt  <= next_pump_cnt;
      low_pump  <= next_low_pump;
      high_pump <= next_high_pump;
    end
  end

  assign low_gate_out     = low_st.gate_on;
  assign high_gate_out    = high_st.gate_on;
  assign up_channel_out   = up_link;
  assign down_channel_out = down_link;
  assign low_pump_clk     = low_pump;
  assign high_pump_clk    = high_pump;
  assign low_status       = low_st;
  assign high_status      = high_st;

  property p_no_overlap;
    @(posedge mclk) disable iff (rst)
      !(low_gate_out && high_gate_out);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("Both gates on together.");
  property p_low_oc_off;
    @(posedge mclk) disable iff (rst)
      (low_s.current_high && low_gate_out) |=> !low_gate_out;
  endproperty
  a_low_oc_off: assert property (p_low_oc_off)
    else $error("Low gate stayed on after overcurrent.");
  property p_high_oc_off;
    @(posedge mclk) disable iff (rst)
      (high_s.current_high && high_gate_out) |=> !high_gate_out;
  endproperty
  a_high_oc_off: assert property (p_high_oc_off)
    else $error("High gate stayed on after overcurrent.");
  property p_low_uv;
    @(posedge mclk) disable iff (rst)
      low_uv |=> !low_gate_out;
  endproperty
  a_low_uv: assert property (p_low_uv)
    else $error("Low gate on under supply fault.");
  property p_high_uv;
    @(posedge mclk) disable iff (rst)
      high_uv |=> !high_gate_out;
  endproperty
  a_high_uv: assert property (p_high_uv)
    else $error("High gate on under supply fault.");
  property p_latch_holds;
    @(posedge mclk) disable iff (rst)
      (low_st.oc_latched && !low_rise) |=> low_st.oc_latched;
  endproperty
  a_latch_holds: assert property (p_latch_holds)
    else $error("Low overcurrent latch cleared without a rising edge.");
  property p_low_cmd_off;
    @(posedge mclk) disable iff (rst)
      !low_cmd |=> !low_gate_out;
  endproperty
  a_low_cmd_off: assert property (p_low_cmd_off)
    else $error("Low gate on without command.");
  property p_high_fault_flag;
    @(posedge mclk) disable iff (rst)
      down_link |=> fault_n_oe;
  endproperty
  a_high_fault_flag: assert property (p_high_fault_flag)
    else $error("High-side fault not shown on fault output.");
  property p_pump_stop;
    @(posedge mclk) disable iff (rst)
      low_s.pump_over |=> $stable(low_pump);
  endproperty
  a_pump_stop: assert property (p_pump_stop)
    else $error("Low pump clock ran above supply limit.");
endmodule : half_bridge_gate_fault_logic

/* verification/pwm_deadtime_model.sv */
// Behavioural model of the PWM controller that feeds both command pins.
`timescale 1ns/1ps

module pwm_deadtime_model #(
  parameter int DEAD = 6
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic want_low,
  input  wire logic want_high,
  input  wire logic overlap,
  output logic      low_cmd,
  output logic      high_cmd
);
  int gap;

  // A side rises only after both commands were low for DEAD cycles; overlap
  // makes the controller faulty on purpose so the lockout can be exercised.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      low_cmd  <= 1'b0;
      high_cmd <= 1'b0;
      gap      <= 0;
    end
    else
    begin
      gap      <= (low_cmd || high_cmd) ? 0 : gap + 1;
      low_cmd  <= want_low && (low_cmd || overlap
                  || (!high_cmd && gap >= DEAD));
      high_cmd <= want_high && (high_cmd || overlap
                  || (!low_cmd && !want_low && gap >= DEAD));
    end
  end
endmodule : pwm_deadtime_model

/* verification/tb_top.sv */
// Self-checking bench for the half-bridge gate fault logic.
`timescale 1ns/1ps

module tb_top;
  import gate_fault_pkg::*;
  // S covers controller dead time plus synchroniser and register latency.
  localparam int S = 16;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  want = 2'b00;
  logic        overlap = 1'b0;
  logic        low_cmd, high_cmd, low_gate_out, high_gate_out;
  logic        up_channel_out, down_channel_out, fault_n_out, fault_n_oe;
  logic        low_pump_clk, high_pump_clk;
  die_sense_s  sense [2];
  die_status_s stat [2];
  int          n_mismatch = 0;
  int          comparisons = 0;
  logic [31:0] seed = 32'hFD07F41E;

  always #20 mclk = ~mclk;

  pwm_deadtime_model u_ctrl (
    .mclk(mclk), .rst(rst), .want_low(want[0]), .want_high(want[1]),
    .overlap(overlap), .low_cmd(low_cmd), .high_cmd(high_cmd));

  half_bridge_gate_fault_logic u_dut (
    .mclk(mclk), .rst(rst), .low_side_command_in(low_cmd),
    .high_side_command_in(high_cmd), .low_sense(sense[0]),
    .high_sense(sense[1]), .low_gate_out(low_gate_out),
    .high_gate_out(high_gate_out), .up_channel_out(up_channel_out),
    .down_channel_out(down_channel_out), .fault_n_out(fault_n_out),
    .fault_n_oe(fault_n_oe), .low_pump_clk(low_pump_clk),
    .high_pump_clk(high_pump_clk), .low_status(stat[0]),
    .high_status(stat[1]));

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic gate(int d);
    return d ? high_gate_out : low_gate_out;
  endfunction : gate

  task automatic check(logic seen, logic exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: saw %b expected %b", $time, seen, exp);
    end
  endtask : check

  task automatic step(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  task automatic pump_count(int d, int lo, int hi);
    int   n;
    logic prev;
    n = 0;
    prev = d ? high_pump_clk : low_pump_clk;
    repeat (400)
    begin
      step(1);
      n += int'((d ? high_pump_clk : low_pump_clk) !== prev);
      prev = d ? high_pump_clk : low_pump_clk;
    end
    check(n >= lo && n <= hi, 1'b1);
  endtask : pump_count

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // Checked on the falling edge so every registered output has settled.
  always @(negedge mclk)
    if (!rst)
      check(low_gate_out && high_gate_out, 1'b0);

  initial
  begin
    #(20000 * 40);
    n_mismatch++;
    tally_and_finish();
  end

  initial
  begin
    sense[0] = '0;
    sense[1] = '0;
    step(1);
    check(low_gate_out, 1'b0);
    check(high_gate_out, 1'b0);
    check(fault_n_oe, 1'b1);
    @(posedge mclk) rst <= 1'b0;
    step(S);
    check(fault_n_oe, 1'b0);
    check(fault_n_out, 1'b0);
    $display("test power-up done");
    for (int d = 0; d < 2; d++)
    begin
      pump_count(d, 400 / PUMP_HALF_DIV - 1, 400 / PUMP_HALF_DIV + 1);
      @(posedge mclk) sense[d].pump_over <= 1'b1;
      step(4);
      pump_count(d, 0, 0);
      @(posedge mclk) sense[d].pump_over <= 1'b0;
    end
    $display("test pump done");
    for (int i = 0; i < 16; i++)
    begin
      seed = lfsr(seed);
      @(posedge mclk) want <= (seed[1:0] == 2'b11) ? 2'b00 : seed[1:0];
      step(S);
      check(low_gate_out, want[0]);
      check(high_gate_out, want[1]);
      check(up_channel_out, want[1]);
    end
    $display("test random commands done");
    for (int d = 0; d < 2; d++)
    begin
      @(posedge mclk) want <= 2'b00;
      step(S);
      @(posedge mclk) sense[d].current_high <= 1'b1;
      step(S);
      check(fault_n_oe, 1'b0);
      @(posedge mclk) sense[d].current_high <= 1'b0;
      want[d] <= 1'b1;
      step(S);
      check(gate(d), 1'b1);
      @(posedge mclk) sense[d].current_high <= 1'b1;
      step(OC_OFF_CYCLES);
      check(gate(d), 1'b0);
      step(2);
      check(fault_n_oe, 1'b1);
      check(down_channel_out, d[0]);
      check(stat[d].oc_latched, 1'b1);
      @(posedge mclk) sense[d].current_high <= 1'b0;
      step(S);
      check(gate(d), 1'b0);
      check(fault_n_oe, 1'b1);
      @(posedge mclk) want[d] <= 1'b0;
      step(S);
      @(posedge mclk) want[d] <= 1'b1;
      step(S);
      check(gate(d), 1'b1);
      check(fault_n_oe, 1'b0);
    end
    $display("test overcurrent done");
    for (int k = 0; k < 4; k++)
    begin
      @(posedge mclk) want <= 2'b01 << k[1];
      step(S);
      @(posedge mclk);
      if (k[0])
        sense[k[1]].neg_supply_bad <= 1'b1;
      else
        sense[k[1]].pos_supply_low <= 1'b1;
      step(S);
      check(gate(k[1]), 1'b0);
      check(fault_n_oe, 1'b1);
      check(stat[k[1]].uv_lock, 1'b1);
      @(posedge mclk) sense[k[1]] <= '0;
      step(S);
      check(fault_n_oe, 1'b0);
      check(stat[k[1]].uv_lock, 1'b0);
      check(gate(k[1]), 1'b1);
    end
    $display("test undervoltage done");
    @(posedge mclk) rst <= 1'b1;
    step(2);
    check(high_gate_out, 1'b0);
    check(fault_n_oe, 1'b1);
    @(posedge mclk) rst <= 1'b0;
    step(S);
    check(fault_n_oe, 1'b0);
    check(high_gate_out, 1'b1);
    $display("test reset done");
    for (int j = 0; j < 2; j++)
    begin
      @(posedge mclk) want <= 2'b01 << j;
      step(S);
      @(posedge mclk) overlap <= 1'b1;
      want <= 2'b11;
      step(S);
      check(low_gate_out, !j[0]);
      check(high_gate_out, 1'b0);
      @(posedge mclk) overlap <= 1'b0;
      want <= 2'b00;
      step(S);
    end
    $display("test lockout done");
    tally_and_finish();
  end
endmodule : tb_top
